// *** srpcs_pkg.sv ***
package srpcs_pkg;

  // register offsets on the plain register port (byte addresses)
  localparam logic [7:0] SRPCS_CFG_OFS    = 8'h00;
  localparam logic [7:0] SRPCS_STAT_OFS   = 8'h04;
  localparam logic [7:0] SRPCS_MASK_OFS   = 8'h08;
  localparam logic [7:0] SRPCS_STATE_OFS  = 8'h0C;

  // channel_config_two field positions
  localparam int SRPCS_SYNC_FILT_BIT  = 0;
  localparam int SRPCS_PAR_FMT_LO     = 1;
  localparam int SRPCS_PAR_EN_BIT     = 3;
  localparam int SRPCS_PAR_STDIS_BIT  = 4;
  localparam int SRPCS_CRC_DIS_BIT    = 5;
  localparam int SRPCS_CRC_FWD_BIT    = 6;
  localparam int SRPCS_ADDR_PUSH_BIT  = 7;
  localparam int SRPCS_FDF_BIT        = 8;
  localparam int SRPCS_MODE_LO        = 9;
  localparam int SRPCS_CLEN_LO        = 11;
  localparam int SRPCS_SUB_LO         = 13;
  localparam int SRPCS_CRC32_BIT      = 15;
  localparam int SRPCS_ADDR16_BIT     = 16;
  localparam int SRPCS_CFG_W          = 17;
  localparam logic [SRPCS_CFG_W-1:0] SRPCS_CFG_RST = 17'h00000;

  // interrupt status / mask bit positions
  localparam int SRPCS_IRQ_PAR_ERR = 0;
  localparam int SRPCS_IRQ_SHORT   = 1;
  localparam int SRPCS_IRQ_CRC_ERR = 2;
  localparam int SRPCS_IRQ_FRM_END = 3;
  localparam int SRPCS_IRQ_W       = 4;
  localparam logic [SRPCS_IRQ_W-1:0] SRPCS_IRQ_RST = 4'h0;

  // protocol modes
  localparam logic [1:0] SRPCS_MODE_ASYNC  = 2'h0;
  localparam logic [1:0] SRPCS_MODE_BISYNC = 2'h1;
  localparam logic [1:0] SRPCS_MODE_HDLC   = 2'h2;

  // hdlc sub-modes
  localparam logic [1:0] SRPCS_SUB_NONAUTO0 = 2'h0;
  localparam logic [1:0] SRPCS_SUB_NONAUTO1 = 2'h1;
  localparam logic [1:0] SRPCS_SUB_AUTO     = 2'h2;

  // character length codes
  localparam logic [1:0] SRPCS_CLEN_8 = 2'h0;
  localparam logic [1:0] SRPCS_CLEN_7 = 2'h1;
  localparam logic [1:0] SRPCS_CLEN_6 = 2'h2;
  localparam logic [1:0] SRPCS_CLEN_5 = 2'h3;

  // parity formats
  localparam logic [1:0] SRPCS_PAR_SPACE = 2'h0;
  localparam logic [1:0] SRPCS_PAR_ODD   = 2'h1;
  localparam logic [1:0] SRPCS_PAR_EVEN  = 2'h2;
  localparam logic [1:0] SRPCS_PAR_MARK  = 2'h3;

  // character status byte layout
  localparam int SRPCS_CST_PE  = 7;
  localparam int SRPCS_CST_FE  = 6;
  localparam int SRPCS_CST_PAR = 0;

  // frame status byte layout
  localparam int SRPCS_FST_VALID = 7;
  localparam int SRPCS_FST_CRCOK = 5;
  localparam int SRPCS_FST_SHORT = 4;

  // checksum and address lengths in bytes
  localparam logic [2:0] SRPCS_CRC16_LEN = 3'h2;
  localparam logic [2:0] SRPCS_CRC32_LEN = 3'h4;
  localparam logic [2:0] SRPCS_NO_LEN    = 3'h0;
  localparam logic [1:0] SRPCS_ADR8_LEN  = 2'h1;
  localparam logic [1:0] SRPCS_ADR16_LEN = 2'h2;
  localparam logic [1:0] SRPCS_ADR0_LEN  = 2'h0;
  localparam int         SRPCS_HOLD_D    = 4;

  // forwarding minimum in the channel fifo
  localparam logic [5:0] SRPCS_FWD_MIN1 = 6'h01;
  localparam logic [5:0] SRPCS_FWD_MIN2 = 6'h02;

  // frame tail sequencer
  typedef enum logic [1:0] {SRPCS_T_IDLE, SRPCS_T_FLUSH, SRPCS_T_STAT} srpcs_tail_e;

endpackage

// *** srpcs_parity.sv ***
`timescale 1ns/1ns
`default_nettype none
module srpcs_parity (
  // character in
  input  wire logic [7:0] data,
  input  wire logic [1:0] clen,
  input  wire logic [1:0] fmt,
  // expected parity bit
  output logic            par
);
  import srpcs_pkg::*;

  logic [7:0] masked;  // data bits beyond the length cleared
  logic       ones;    // xor of the data bits

  // mask by length, then pick the bit the format asks for
  always_comb begin
    case (clen)
      SRPCS_CLEN_7: masked = data & 8'h7F;
      SRPCS_CLEN_6: masked = data & 8'h3F;
      SRPCS_CLEN_5: masked = data & 8'h1F;
      default:      masked = data;
    endcase
    ones = ^masked;
    case (fmt)
      SRPCS_PAR_SPACE: par = 1'b0;
      SRPCS_PAR_ODD:   par = ~ones;
      SRPCS_PAR_EVEN:  par = ones;
      default:         par = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// *** srpcs_rx.sv ***
// Overview of operation
// - bisync filter set: drop sync characters
// - parity format: space, odd, even, mark
// - short characters: parity stored above data
// - 8-bit two-byte format: parity in status lsb
// - parity error in status byte msb
// - parity error raises interrupt
// - parity enable switches checking on/off
// - storage disable drops parity from data
// - crc expected; short frames discarded
// - crc disabled: no checksum, forward ignored
// - forwarding only non-auto address mode zero
// - forward off: checksum checked, not stored
// - forward on: checksum stored as data
// - address push delivers address field
// - hdlc forward after one or two bytes
`timescale 1ns/1ns
`default_nettype none
module srpcs_rx (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  // characters from the async/bisync deserialiser
  input  wire logic        char_valid,
  input  wire logic [7:0]  char_data,
  input  wire logic        char_par,
  input  wire logic        char_sync,
  input  wire logic        char_frame_err,
  // bytes from the hdlc deframer
  input  wire logic        hb_valid,
  input  wire logic [7:0]  hb_data,
  input  wire logic        hb_end,
  input  wire logic        hb_crc_ok,
  // channel receive fifo
  output logic             fifo_wr,
  output logic      [7:0]  fifo_wdata,
  output logic             fifo_is_status,
  output logic             fifo_frame_end,
  input  wire logic [5:0]  fifo_level,
  output logic             central_fwd_req
);
  import srpcs_pkg::*;

  logic [SRPCS_CFG_W-1:0] channel_config_two_ff;  // configuration
  logic [SRPCS_IRQ_W-1:0] irq_stat_ff;            // sticky events
  logic [SRPCS_IRQ_W-1:0] irq_mask_ff;            // interrupt enables
  logic [SRPCS_IRQ_W-1:0] ev;                     // event pulses this cycle

  // configuration fields
  logic       sync_char_load_filter;
  logic [1:0] parity_format;
  logic       parity_enable;
  logic       parity_storage_disable;
  logic       rx_crc_check_disable;
  logic       rx_crc_forward;
  logic       rx_address_push;
  logic       rx_fifo_data_format;
  logic [1:0] mode;
  logic [1:0] clen;
  logic [1:0] sub;
  assign sync_char_load_filter  = channel_config_two_ff[SRPCS_SYNC_FILT_BIT];
  assign parity_format          = channel_config_two_ff[SRPCS_PAR_FMT_LO +: 2];
  assign parity_enable          = channel_config_two_ff[SRPCS_PAR_EN_BIT];
  assign parity_storage_disable = channel_config_two_ff[SRPCS_PAR_STDIS_BIT];
  assign rx_crc_check_disable   = channel_config_two_ff[SRPCS_CRC_DIS_BIT];
  assign rx_crc_forward         = channel_config_two_ff[SRPCS_CRC_FWD_BIT];
  assign rx_address_push        = channel_config_two_ff[SRPCS_ADDR_PUSH_BIT];
  assign rx_fifo_data_format    = channel_config_two_ff[SRPCS_FDF_BIT];
  assign mode                   = channel_config_two_ff[SRPCS_MODE_LO +: 2];
  assign clen                   = channel_config_two_ff[SRPCS_CLEN_LO +: 2];
  assign sub                    = channel_config_two_ff[SRPCS_SUB_LO +: 2];

  // ---------------- character path ----------------
  logic       exp_par;      // expected parity bit
  logic       char_take;    // character accepted for storage
  logic       par_err;      // parity mismatch on a taken character
  logic [7:0] char_byte;    // stored data byte
  logic [7:0] char_stat;    // status byte that follows it
  logic       cst_pend_ff;  // status byte waiting one cycle
  logic [7:0] cst_ff;       // held status byte

  srpcs_parity u_par (
    .data (char_data),
    .clen (clen),
    .fmt  (parity_format),
    .par  (exp_par)
  );

  // accept characters in every mode except hdlc
  always_comb begin
    char_take = char_valid && (mode != SRPCS_MODE_HDLC);
    if (mode == SRPCS_MODE_BISYNC && sync_char_load_filter && char_sync) begin
      char_take = 1'b0;
    end
    par_err = char_take && parity_enable && (char_par != exp_par);
    char_byte = char_data;
    case (clen)
      SRPCS_CLEN_7: char_byte[7] = parity_enable && !parity_storage_disable && char_par;
      SRPCS_CLEN_6: char_byte[7:6] = {1'b0, parity_enable && !parity_storage_disable && char_par};
      SRPCS_CLEN_5: char_byte[7:5] = {2'h0, parity_enable && !parity_storage_disable && char_par};
      default: char_byte = char_data;
    endcase
    char_stat = 8'h00;
    char_stat[SRPCS_CST_PE]  = par_err;
    char_stat[SRPCS_CST_FE]  = char_frame_err;
    char_stat[SRPCS_CST_PAR] = parity_enable && char_par;
  end

  // hold the status byte for the cycle after its character
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cst_pend_ff <= 1'b0;
      cst_ff      <= 8'h00;
    end else begin
      cst_pend_ff <= char_take && rx_fifo_data_format;
      if (char_take) begin
        cst_ff <= char_stat;
      end
    end
  end

  // ---------------- hdlc path ----------------
  logic [2:0]  crc_len;       // checksum bytes held back
  logic [1:0]  adr_len;       // address bytes at frame start
  logic        fwd_eff;       // checksum forwarding in force
  logic [7:0]  byte_cnt_ff;   // bytes seen in this frame
  logic [7:0]  hold_ff [SRPCS_HOLD_D];  // tail holding line, newest at 0
  logic [2:0]  hold_cnt_ff;   // bytes in the holding line
  srpcs_tail_e tail_ff;       // frame tail sequencer
  logic [7:0]  fst_ff;        // frame status byte
  logic        hb_in;         // byte accepted this cycle
  logic        hb_keep;       // byte goes toward the fifo
  logic        hb_emit;       // oldest held byte leaves as data
  logic [7:0]  hb_out;        // that byte
  logic        frm_short;     // frame no longer than its checksum
  logic        frm_valid;     // frame passes the criteria

  always_comb begin
    hb_in = hb_valid && (mode == SRPCS_MODE_HDLC) && (tail_ff == SRPCS_T_IDLE);
    if (rx_crc_check_disable) begin
      crc_len = SRPCS_NO_LEN;
    end else if (channel_config_two_ff[SRPCS_CRC32_BIT]) begin
      crc_len = SRPCS_CRC32_LEN;
    end else begin
      crc_len = SRPCS_CRC16_LEN;
    end
    if (sub == SRPCS_SUB_NONAUTO0) begin
      adr_len = SRPCS_ADR0_LEN;
    end else if (channel_config_two_ff[SRPCS_ADDR16_BIT]) begin
      adr_len = SRPCS_ADR16_LEN;
    end else begin
      adr_len = SRPCS_ADR8_LEN;
    end
    fwd_eff = rx_crc_forward && !rx_crc_check_disable && (sub == SRPCS_SUB_NONAUTO0);
    hb_keep = hb_in && (rx_address_push || (byte_cnt_ff >= {6'h00, adr_len}));
    hb_emit = hb_keep && (hold_cnt_ff == crc_len) && (crc_len != SRPCS_NO_LEN);
    hb_out  = hold_ff[crc_len[1:0] - 2'h1];
    frm_short = (byte_cnt_ff < {5'h00, crc_len});
    frm_valid = !frm_short && (rx_crc_check_disable || hb_crc_ok);
  end

  // count frame bytes; cleared when the tail is done
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      byte_cnt_ff <= 8'h00;
    end else if (tail_ff == SRPCS_T_STAT) begin
      byte_cnt_ff <= 8'h00;
    end else if (hb_in && byte_cnt_ff != 8'hFF) begin
      byte_cnt_ff <= byte_cnt_ff + 8'h01;
    end
  end

  // holding line keeps the last crc_len bytes back from the fifo
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_cnt_ff <= 3'h0;
      for (int i = 0; i < SRPCS_HOLD_D; i++) begin
        hold_ff[i] <= 8'h00;
      end
    end else if (tail_ff == SRPCS_T_FLUSH) begin
      hold_cnt_ff <= hold_cnt_ff - 3'h1;
    end else if (tail_ff == SRPCS_T_STAT) begin
      hold_cnt_ff <= 3'h0;
    end else if (hb_keep && crc_len != SRPCS_NO_LEN) begin
      hold_ff[0] <= hb_data;
      for (int i = 1; i < SRPCS_HOLD_D; i++) begin
        hold_ff[i] <= hold_ff[i-1];
      end
      if (!hb_emit) begin
        hold_cnt_ff <= hold_cnt_ff + 3'h1;
      end
    end
  end

  // frame tail: optional checksum flush, then frame status byte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tail_ff <= SRPCS_T_IDLE;
      fst_ff  <= 8'h00;
    end else begin
      case (tail_ff)
        SRPCS_T_IDLE: begin
          if (hb_valid && hb_end && mode == SRPCS_MODE_HDLC) begin
            fst_ff <= 8'h00;
            fst_ff[SRPCS_FST_VALID] <= frm_valid;
            fst_ff[SRPCS_FST_CRCOK] <= hb_crc_ok;
            fst_ff[SRPCS_FST_SHORT] <= frm_short;
            if (fwd_eff && hold_cnt_ff != 3'h0 && !frm_short) begin
              tail_ff <= SRPCS_T_FLUSH;
            end else begin
              tail_ff <= SRPCS_T_STAT;
            end
          end
        end
        SRPCS_T_FLUSH: begin
          if (hold_cnt_ff == 3'h1) begin
            tail_ff <= SRPCS_T_STAT;
          end
        end
        SRPCS_T_STAT: tail_ff <= SRPCS_T_IDLE;
        default:      tail_ff <= SRPCS_T_IDLE;
      endcase
    end
  end

  // ---------------- fifo write port ----------------
  // one write per cycle; the sources never collide given input spacing
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fifo_wr        <= 1'b0;
      fifo_wdata     <= 8'h00;
      fifo_is_status <= 1'b0;
      fifo_frame_end <= 1'b0;
    end else begin
      fifo_wr        <= 1'b0;
      fifo_is_status <= 1'b0;
      fifo_frame_end <= 1'b0;
      if (cst_pend_ff) begin
        fifo_wr        <= 1'b1;
        fifo_wdata     <= cst_ff;
        fifo_is_status <= 1'b1;
      end else if (char_take) begin
        fifo_wr    <= 1'b1;
        fifo_wdata <= char_byte;
      end else if (tail_ff == SRPCS_T_FLUSH) begin
        fifo_wr    <= 1'b1;
        fifo_wdata <= hold_ff[hold_cnt_ff[1:0] - 2'h1];
      end else if (tail_ff == SRPCS_T_STAT) begin
        fifo_wr        <= 1'b1;
        fifo_wdata     <= fst_ff;
        fifo_is_status <= 1'b1;
        fifo_frame_end <= 1'b1;
      end else if (hb_keep && crc_len == SRPCS_NO_LEN) begin
        fifo_wr    <= 1'b1;
        fifo_wdata <= hb_data;
      end else if (hb_emit) begin
        fifo_wr    <= 1'b1;
        fifo_wdata <= hb_out;
      end
    end
  end

  // hdlc forwarding minimum of one byte, or two bytes with the two-byte fifo data format
  always_comb begin
    central_fwd_req = 1'b0;
    if (mode == SRPCS_MODE_HDLC) begin
      central_fwd_req = fifo_level >= (rx_fifo_data_format ? SRPCS_FWD_MIN2 : SRPCS_FWD_MIN1);
    end else if (fifo_level != 6'h00) begin
      central_fwd_req = 1'b1;
    end
  end

  // ---------------- registers and interrupt ----------------
  always_comb begin
    ev = '0;
    ev[SRPCS_IRQ_PAR_ERR] = par_err;
    ev[SRPCS_IRQ_SHORT]   = (tail_ff == SRPCS_T_STAT) && fst_ff[SRPCS_FST_SHORT];
    ev[SRPCS_IRQ_CRC_ERR] = (tail_ff == SRPCS_T_STAT) && !rx_crc_check_disable && !fst_ff[SRPCS_FST_CRCOK];
    ev[SRPCS_IRQ_FRM_END] = (tail_ff == SRPCS_T_STAT);
  end

  // configuration register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      channel_config_two_ff <= SRPCS_CFG_RST;
    end else if (reg_wr && reg_addr == SRPCS_CFG_OFS) begin
      channel_config_two_ff <= reg_wdata[SRPCS_CFG_W-1:0];
    end
  end

  // sticky status: write one clears, a new event wins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_stat_ff <= SRPCS_IRQ_RST;
    end else if (reg_wr && reg_addr == SRPCS_STAT_OFS) begin
      irq_stat_ff <= (irq_stat_ff & ~reg_wdata[SRPCS_IRQ_W-1:0]) | ev;
    end else begin
      irq_stat_ff <= irq_stat_ff | ev;
    end
  end

  // interrupt mask
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_mask_ff <= SRPCS_IRQ_RST;
    end else if (reg_wr && reg_addr == SRPCS_MASK_OFS) begin
      irq_mask_ff <= reg_wdata[SRPCS_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        SRPCS_CFG_OFS:   reg_rdata <= {15'h0000, channel_config_two_ff};
        SRPCS_STAT_OFS:  reg_rdata <= {28'h0000000, irq_stat_ff};
        SRPCS_MASK_OFS:  reg_rdata <= {28'h0000000, irq_mask_ff};
        SRPCS_STATE_OFS: reg_rdata <= {19'h00000, hold_cnt_ff, tail_ff, byte_cnt_ff};
        default:         reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// *** srpcs_rx_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module srpcs_rx_chk
  import srpcs_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // line side
  input wire logic        char_valid,
  input wire logic [7:0]  char_data,
  input wire logic        char_par,
  input wire logic        char_sync,
  input wire logic        char_frame_err,
  input wire logic        hb_valid,
  input wire logic [7:0]  hb_data,
  input wire logic        hb_end,
  // channel fifo side
  input wire logic        fifo_wr,
  input wire logic [7:0]  fifo_wdata,
  input wire logic        fifo_is_status,
  input wire logic        fifo_frame_end,
  input wire logic [5:0]  fifo_level,
  input wire logic        central_fwd_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [16:0] cfg_ff;      // shadow of the configuration register
  logic [7:0]  exp_dat_ff;  // expected data byte of the last character
  logic [7:0]  exp_st_ff;   // expected status byte of the last character
  wire logic [1:0] mode = cfg_ff[10:9];
  wire logic [1:0] clen = cfg_ff[12:11];
  wire logic       pen  = cfg_ff[3];
  wire logic       chr  = (mode != SRPCS_MODE_HDLC);
  wire logic       drop = char_sync && cfg_ff[0] && mode == SRPCS_MODE_BISYNC;
  // expected parity bit for the current length and format
  function automatic logic par_of(input logic [7:0] d, input logic [1:0] cl, input logic [1:0] f);
    logic [7:0] m;
    m = d & (8'hFF >> cl);
    case (f)
      SRPCS_PAR_ODD:  par_of = ~^m;
      SRPCS_PAR_EVEN: par_of = ^m;
      default:        par_of = f[0];
    endcase
  endfunction
  // track configuration writes and the expected bytes of each character
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= '0;
      exp_dat_ff <= 8'h00;
      exp_st_ff <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == SRPCS_CFG_OFS) begin
        cfg_ff <= reg_wdata[16:0];
      end
      if (char_valid) begin
        exp_dat_ff <= (char_data & (8'hFF >> clen))
                    | ((pen && !cfg_ff[4] && clen != SRPCS_CLEN_8) ? 8'(char_par) << (4'h8 - {2'h0, clen}) : 8'h00);
        exp_st_ff <= {pen && (char_par != par_of(char_data, clen, cfg_ff[2:1])), char_frame_err, 5'h00, pen && char_par};
      end
    end
  end
  rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read slot");
  sync_drop_a: assert property (char_valid && chr && drop |=> !fifo_wr)
    else $error("sync character was stored");
  char_data_a: assert property (char_valid && chr && !drop |=> fifo_wr && !fifo_is_status && fifo_wdata == exp_dat_ff)
    else $error("character data byte wrong");
  char_stat_a: assert property (char_valid && chr && !drop && cfg_ff[8] |-> ##2 fifo_wr && fifo_is_status && fifo_wdata == exp_st_ff)
    else $error("character status byte wrong");
  char_single_a: assert property (char_valid && chr && !cfg_ff[8] |-> ##2 !fifo_wr)
    else $error("status byte written in one-byte format");
  fwd_level_a: assert property (central_fwd_req == (chr ? fifo_level != 6'h00 : fifo_level >= {5'h00, cfg_ff[8]} + 6'h01))
    else $error("forward request level wrong");
  frame_close_a: assert property (hb_valid && hb_end && !chr |-> ##[1:7] fifo_frame_end)
    else $error("frame status byte missing");
  end_marks_a: assert property (fifo_frame_end |-> fifo_wr && fifo_is_status)
    else $error("frame end without status write");
  crc_pass_a: assert property (hb_valid && !hb_end && !chr && cfg_ff[5] && cfg_ff[14:13] == SRPCS_SUB_NONAUTO0
                               |=> fifo_wr && !fifo_is_status && fifo_wdata == $past(hb_data))
    else $error("byte held without checksum");
  sync_drop_c: cover property (char_valid && drop);
  par_err_c: cover property (fifo_wr && fifo_is_status && fifo_wdata[7]);
  frame_end_c: cover property (fifo_frame_end);
endmodule
bind srpcs_rx srpcs_rx_chk u_chk (.*);
`default_nettype wire

// *** srpcs_line_peer.sv ***
`timescale 1ns/1ns
`default_nettype none
module srpcs_line_peer (
  // clock
  input  wire logic       ref_clk,
  // characters
  output var logic        char_valid,
  output var logic [7:0]  char_data,
  output var logic        char_par,
  output var logic        char_sync,
  output var logic        char_frame_err,
  // hdlc bytes
  output var logic        hb_valid,
  output var logic [7:0]  hb_data,
  output var logic        hb_end,
  output var logic        hb_crc_ok
);
  // quiet line at time zero
  initial begin
    {char_valid, char_data, char_par, char_sync, char_frame_err} = '0;
    {hb_valid, hb_data, hb_end, hb_crc_ok} = '0;
  end
  // one character; returns at the edge that takes it
  task automatic send_char(input logic [7:0] d, input logic p, input logic s, input logic fe);
    @(posedge ref_clk);
    char_valid <= 1'b1;
    {char_data, char_par, char_sync, char_frame_err} <= {d, p, s, fe};
    @(posedge ref_clk);
    char_valid <= 1'b0;
    {char_data, char_par} <= ~{d, p};  // stale values are not kept
  endtask
  // one frame, bytes two cycles apart, then the idle gap the tail needs
  task automatic send_frame(input int n, input logic [7:0] b[8], input logic ok);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      {hb_valid, hb_data, hb_end, hb_crc_ok} <= {1'b1, b[i], i == n - 1, ok};
      @(posedge ref_clk);
      {hb_valid, hb_data, hb_end, hb_crc_ok} <= {1'b0, ~b[i], 1'b0, ~ok};
    end
    repeat (8) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// *** srpcs_rx_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module srpcs_rx_test;
  import srpcs_pkg::*;
  // clock, reset and register port
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        irq;
  // line and fifo side
  logic        char_valid, char_par, char_sync, char_frame_err, hb_valid, hb_end, hb_crc_ok;
  logic [7:0]  char_data, hb_data, fifo_wdata;
  logic        fifo_wr, fifo_is_status, fifo_frame_end, central_fwd_req;
  logic [5:0]  fifo_level = 6'h00;
  // bookkeeping
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  integer      seed = 32'hC08C;
  logic [9:0]  seen_q[$];  // fifo writes: is_status, frame_end, byte
  always #4 ref_clk = ~ref_clk;
  srpcs_rx uut (.*);
  srpcs_line_peer peer (.ref_clk(ref_clk), .char_valid(char_valid), .char_data(char_data), .char_par(char_par),
    .char_sync(char_sync), .char_frame_err(char_frame_err), .hb_valid(hb_valid), .hb_data(hb_data),
    .hb_end(hb_end), .hb_crc_ok(hb_crc_ok));
  // record every fifo write and cut a hang short
  always @(posedge ref_clk) begin
    if (fifo_wr === 1'b1) seen_q.push_back({fifo_is_status, fifo_frame_end, fifo_wdata});
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // expected status byte and data byte of one character under config c
  function automatic logic [15:0] char_exp(input logic [16:0] c, input logic [7:0] d, input logic p, input logic fe);
    logic [7:0] m;
    logic       ep;
    m = d & (8'hFF >> c[12:11]);
    case (c[2:1])
      SRPCS_PAR_ODD:  ep = ~^m;
      SRPCS_PAR_EVEN: ep = ^m;
      default:        ep = c[1];
    endcase
    if (c[3] && !c[4] && c[12:11] != SRPCS_CLEN_8) m[8 - c[12:11]] = p;
    char_exp = {c[3] && (p != ep), fe, 5'h00, c[3] && p, m};
  endfunction
  // one hdlc frame against the expected fifo writes and status register
  task automatic frame(input logic [16:0] c, input int n, input logic ok);
    logic [7:0]  b[8];
    logic [9:0]  exp_q[$];
    logic [31:0] v;
    int          crc, drp;
    logic        fwd, shrt;
    foreach (b[i]) b[i] = 8'($random(seed));
    wr(SRPCS_CFG_OFS, 32'(c));
    seen_q.delete();
    peer.send_frame(n, b, ok);
    crc = c[5] ? 0 : (c[15] ? 4 : 2);
    fwd = !c[5] && c[6] && c[14:13] == SRPCS_SUB_NONAUTO0;
    drp = (c[14:13] != SRPCS_SUB_NONAUTO0 && !c[7]) ? (c[16] ? 2 : 1) : 0;
    shrt = n <= crc;
    for (int i = drp; i < n - crc; i++) exp_q.push_back({2'b00, b[i]});
    for (int i = n - crc; i < n && fwd && !shrt; i++) exp_q.push_back({2'b00, b[i]});
    exp_q.push_back({2'b11, !shrt && (c[5] || ok), 1'b0, ok, shrt, 4'h0});
    check("frame write count", seen_q.size(), exp_q.size());
    for (int i = 0; i < exp_q.size() && i < seen_q.size(); i++) begin
      v = (i == exp_q.size() - 1 && (c[5] || shrt)) ? 32'h39F : 32'h3FF;
      check("frame fifo byte", seen_q[i] & v, exp_q[i] & v);
    end
    rd(SRPCS_STAT_OFS, v);
    check("frame events", v, {!c[5] && !ok, shrt, 1'b0} | 32'h8);
    wr(SRPCS_STAT_OFS, 32'hF);
    for (int l = 0; l < 4; l++) begin
      @(posedge ref_clk);
      fifo_level <= 6'(l);
      #1 check("hdlc forward request", central_fwd_req, l >= (c[8] ? 2 : 1));
    end
  endtask
  initial begin
    logic [31:0] v;
    logic [16:0] cfg;
    logic [15:0] e;
    logic [7:0]  d;
    logic        p, s, fe, msk, drop, pe;
    logic [16:0] frm_cfg[11] = '{17'h00440, 17'h00400, 17'h08440, 17'h00460, 17'h00440, 17'h00400,
                                 17'h02440, 17'h14480, 17'h12400, 17'h00540, 17'h08400};
    int          frm_len[11] = '{4, 5, 7, 3, 2, 3, 5, 6, 6, 4, 4};
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, and an unmapped place that ignores writes
    wr(8'h40, 32'hFFFFFFFF);
    for (int k = 0; k < 5; k++) begin
      rd(k == 4 ? 8'h40 : 8'(k * 4), v);
      check("reset register", v, 32'h0);
    end
    $display("test reset values done");
    // random characters across every format, length and option
    for (int i = 0; i < 64; i++) begin
      cfg = 17'($random(seed)) & 17'h019FF;
      cfg[10:9] = {1'b0, 1'($random(seed))};
      cfg[2:1] = 2'(i);
      {d, p, s, fe, msk} = 12'($random(seed));
      wr(SRPCS_CFG_OFS, 32'(cfg));
      wr(SRPCS_MASK_OFS, 32'(msk));
      fifo_level <= 6'($random(seed));
      peer.send_char(d, p, s, fe);
      drop = s && cfg[0] && cfg[10:9] == SRPCS_MODE_BISYNC;
      e = char_exp(cfg, d, p, fe);
      #1 check("fifo write", fifo_wr, !drop);
      if (!drop) check("char data", fifo_wdata, e[7:0]);
      @(posedge ref_clk);
      #1 check("status slot", {fifo_wr, fifo_is_status, fifo_wr ? fifo_wdata : 8'h00}, (!drop && cfg[8]) ? {2'b11, e[15:8]} : 0);
      check("char forward request", central_fwd_req, fifo_level != 6'h00);
      pe = !drop && e[15];
      rd(SRPCS_STAT_OFS, v);
      check("parity event", v, 32'(pe));
      check("irq", irq, pe & msk);
      wr(SRPCS_STAT_OFS, 32'hF);
      #1 check("irq cleared", irq, 1'b0);
    end
    $display("test characters done");
    wr(SRPCS_MASK_OFS, 32'h0);
    foreach (frm_cfg[i]) frame(frm_cfg[i], frm_len[i], i != 5 && i != 10);
    $display("test frames done");
    conclude();
  end
endmodule
`default_nettype wire
